/* File: pkg/gpios_pkg.sv */
// Constants for the eight-pin sensing GPIO port.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses below 0x80.
package gpios_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_DIR     = 8'h00;
    localparam logic [7:0] OFS_DIRSET  = 8'h04;
    localparam logic [7:0] OFS_DIRCLR  = 8'h08;
    localparam logic [7:0] OFS_DIRTGL  = 8'h0c;
    localparam logic [7:0] OFS_OUT     = 8'h10;
    localparam logic [7:0] OFS_OUTSET  = 8'h14;
    localparam logic [7:0] OFS_OUTCLR  = 8'h18;
    localparam logic [7:0] OFS_OUTTGL  = 8'h1c;
    localparam logic [7:0] OFS_IN      = 8'h20;
    localparam logic [7:0] OFS_MPCMASK = 8'h24;
    localparam logic [7:0] OFS_CFGALL  = 8'h28;
    localparam logic [7:0] OFS_INT0M   = 8'h2c;
    localparam logic [7:0] OFS_INT1M   = 8'h30;
    localparam logic [7:0] OFS_FLAGS   = 8'h34;
    localparam logic [7:0] OFS_BITOP   = 8'h38;
    localparam logic [7:0] OFS_OUTCTL  = 8'h3c;
    localparam logic [7:0] OFS_REMAP   = 8'h40;
    localparam logic [2:0] OFS_CFG_HI  = 3'h3;
    // ------------------------------------------------------------------
    // Pin configuration fields
    // ------------------------------------------------------------------
    localparam int CFG_ISC_LSB = 0;
    localparam int CFG_OPC_LSB = 2;
    localparam int CFG_INV_BIT = 5;
    localparam int CFG_W       = 6;
    typedef enum logic [1:0] {ISC_BOTH = 2'h0, ISC_RISE = 2'h1, ISC_FALL = 2'h2, ISC_LOW = 2'h3} gpios_isc_type;
    localparam logic [2:0] OPC_TOTEM  = 3'h0;
    localparam logic [2:0] OPC_KEEP   = 3'h1;
    localparam logic [2:0] OPC_PD     = 3'h2;
    localparam logic [2:0] OPC_PU     = 3'h3;
    localparam logic [2:0] OPC_WOR    = 3'h4;
    localparam logic [2:0] OPC_WAND   = 3'h5;
    localparam logic [2:0] OPC_WORPD  = 3'h6;
    localparam logic [2:0] OPC_WANDPU = 3'h7;
    // ------------------------------------------------------------------
    // Output control, bit operation and remap fields
    // ------------------------------------------------------------------
    localparam int OCT_PCLK_LSB = 0;
    localparam int OCT_PCLK_EN  = 3;
    localparam int OCT_RTC_LSB  = 4;
    localparam int OCT_RTC_EN   = 7;
    localparam int OCT_EVO_LSB  = 8;
    localparam int OCT_EVO_EN   = 11;
    localparam int OCT_EVCH_LSB = 12;
    localparam int OCT_W        = 14;
    localparam int BOP_BIT_LSB  = 0;
    localparam int BOP_VAL_BIT  = 3;
    localparam int BOP_TGT_BIT  = 4;
    localparam int REMAP_W      = 4;
    // ------------------------------------------------------------------
    // Reset values and bus responses
    // ------------------------------------------------------------------
    localparam logic [7:0]        RST_PORT   = 8'h00;
    localparam logic [CFG_W-1:0]  RST_CFG    = 6'h00;
    localparam logic [OCT_W-1:0]  RST_OUTCTL = 14'h0000;
    localparam logic [1:0]        RESP_OKAY  = 2'h0;
    localparam logic [1:0]        RESP_SLV   = 2'h2;
endpackage

/* File: verilog/gpios_port.sv */
// Eight-pin GPIO port with edge/level sensing, two pin interrupts and events.
// Assumes an AXI4-Lite master on clk_i and pads resolved by the surroundings.
// Overview of operation
// - Up to eight pins, numbered from zero
// - Each pin input or output, own configuration
// - Totem, wired-AND, wired-OR, keeper, inverted modes
// - Pull-up or pull-down for inputs and wired modes
// - Keeper weakly holds the last pin level
// - Sense both, rising, falling edge or low level
// - Synchronous sensing only while port clock runs
// - Asynchronous pin change wakes from any sleep
// - Inverted pins invert before the sensing logic
// - Two port interrupts with per-pin masks
// - Set, clear, toggle locations change addressed bits
// - Direction change leaves other pins untouched
// - One write configures all selected pins
// - Single bits set or cleared directly
// - Peripheral and RTC clocks drivable onto pins
// - Event channels drivable onto pins
// - Serial, SPI, timer pins remappable
// - Alternate function may override pin drive
`timescale 1ns/1ps
module gpios_port #(
    parameter int NP = 8
) (
    input  wire logic                          clk_i,
    input  wire logic                          srst_i,
    input  wire logic                          pclk_en_i,
    input  wire logic [7:0]                    awaddr_i,
    input  wire logic                          awvalid_i,
    output logic                               awready_o,
    input  wire logic [31:0]                   wdata_i,
    input  wire logic [3:0]                    wstrb_i,
    input  wire logic                          wvalid_i,
    output logic                               wready_o,
    output logic [1:0]                         bresp_o,
    output logic                               bvalid_o,
    input  wire logic                          bready_i,
    input  wire logic [7:0]                    araddr_i,
    input  wire logic                          arvalid_i,
    output logic                               arready_o,
    output logic [31:0]                        rdata_o,
    output logic [1:0]                         rresp_o,
    output logic                               rvalid_o,
    input  wire logic                          rready_i,
    input  wire logic [NP-1:0]                 pad_in_i,
    output logic [NP-1:0]                      pad_out_o,
    output logic [NP-1:0]                      pad_oe_o,
    output logic [NP-1:0]                      pull_en_o,
    output logic [NP-1:0]                      pull_up_o,
    input  wire logic                          rtc_clk_i,
    input  wire logic [3:0]                    ev_chan_i,
    input  wire logic [NP-1:0]                 alt_en_i,
    input  wire logic [NP-1:0]                 alt_out_i,
    input  wire logic [NP-1:0]                 alt_oe_i,
    output logic [gpios_pkg::REMAP_W-1:0]      remap_o,
    output logic [NP-1:0]                      evt_o,
    output logic                               int0_o,
    output logic                               int1_o,
    output logic                               wake_o
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NP-1:0]                        dir, out, mpc, m0, m1, flg;
        logic [NP-1:0]                        s1, s2, s3, stab, evt, pdo, poe, pen, pup;
        logic [NP-1:0][gpios_pkg::CFG_W-1:0]  cfg;
        logic [gpios_pkg::OCT_W-1:0]          octl;
        logic [gpios_pkg::REMAP_W-1:0]        remap;
        logic [2:0]                           rs;
        logic                                 rstab, pdiv;
        logic                                 awv, wv, bv, rv;
        logic [7:0]                           awa;
        logic [31:0]                          wd, rd;
        logic [3:0]                           ws;
        logic [1:0]                           br, rr;
    } gpios_state_type;

    gpios_state_type q, n;
    logic [NP-1:0]   set_v;
    logic [NP-1:0]   agree;
    logic            wr_now;

    if (NP < 1 || NP > 8) begin : g_chk
        $error("NP must lie between 1 and 8");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic sense(input logic [1:0] isc, input logic o, input logic nw);
        case (gpios_pkg::gpios_isc_type'(isc))
            gpios_pkg::ISC_BOTH: sense = o ^ nw;
            gpios_pkg::ISC_RISE: sense = ~o & nw;
            gpios_pkg::ISC_FALL: sense = o & ~nw;
            default:             sense = ~nw;
        endcase
    endfunction

    function automatic logic cfg_hit(input logic [7:0] a);
        cfg_hit = (a[7:5] == gpios_pkg::OFS_CFG_HI) && (a[1:0] == 2'h0) && (int'(a[4:2]) < NP);
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = ((a[1:0] == 2'h0) && (a <= gpios_pkg::OFS_REMAP)) || cfg_hit(a);
    endfunction

    function automatic logic [31:0] smask(input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            smask[8*b +: 8] = {8{s[b]}};
        end
    endfunction

    assign awready_o = !q.awv && !q.bv;
    assign wready_o  = !q.wv && !q.bv;
    assign arready_o = !q.rv;
    assign wr_now    = q.awv && q.wv;
    assign agree     = q.s2 ~^ q.s3;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0]   m;
        logic [31:0]   w;
        logic [NP-1:0] wn;
        logic [NP-1:0] clr;
        logic [2:0]    b;
        logic          v, oe, pe, pu, inv;
        logic [2:0]    opc;
        m   = smask(q.ws);
        w   = q.wd & m;
        wn  = w[NP-1:0];
        clr = '0;
        b   = w[gpios_pkg::BOP_BIT_LSB +: 3];
        v   = 1'b0;
        oe  = 1'b0;
        pe  = 1'b0;
        pu  = 1'b0;
        inv = 1'b0;
        opc = '0;
        n   = q;
        set_v = '0;
        // Pin and RTC clock synchronisers; a change counts once stages two and three agree
        n.s1 = pad_in_i;
        n.s2 = q.s1;
        n.s3 = q.s2;
        for (int i = 0; i < NP; i++) begin
            if (agree[i]) begin
                n.stab[i] = q.s3[i];
            end
        end
        n.rs = {q.rs[1:0], rtc_clk_i};
        if (q.rs[1] == q.rs[2]) begin
            n.rstab = q.rs[2];
        end
        n.pdiv = ~q.pdiv;
        // Edge and level detection on the inverted-as-configured pin value
        if (pclk_en_i) begin
            for (int i = 0; i < NP; i++) begin
                inv      = q.cfg[i][gpios_pkg::CFG_INV_BIT];
                set_v[i] = sense(q.cfg[i][gpios_pkg::CFG_ISC_LSB +: 2],
                                 q.stab[i] ^ inv, n.stab[i] ^ inv);
            end
        end
        n.evt = set_v;
        // Read channel
        if (arvalid_i && arready_o) begin
            n.rv = 1'b1;
            n.rr = addr_ok(araddr_i) ? gpios_pkg::RESP_OKAY : gpios_pkg::RESP_SLV;
            n.rd = '0;
            case (araddr_i)
                gpios_pkg::OFS_DIR:     n.rd = 32'(q.dir);
                gpios_pkg::OFS_OUT:     n.rd = 32'(q.out);
                gpios_pkg::OFS_IN:      n.rd = 32'(q.stab);
                gpios_pkg::OFS_MPCMASK: n.rd = 32'(q.mpc);
                gpios_pkg::OFS_INT0M:   n.rd = 32'(q.m0);
                gpios_pkg::OFS_INT1M:   n.rd = 32'(q.m1);
                gpios_pkg::OFS_FLAGS: begin
                    n.rd = 32'(q.flg);
                    clr  = q.flg;
                end
                gpios_pkg::OFS_OUTCTL:  n.rd = 32'(q.octl);
                gpios_pkg::OFS_REMAP:   n.rd = 32'(q.remap);
                default: begin
                    if (cfg_hit(araddr_i)) begin
                        n.rd = 32'(q.cfg[araddr_i[4:2]]);
                    end
                end
            endcase
        end else if (q.rv && rready_i) begin
            n.rv = 1'b0;
        end
        // Sticky flags: a new event wins over the clear-on-read
        n.flg = (q.flg & ~clr) | set_v;
        // Write channel: address and data taken in either order
        if (awvalid_i && awready_o) begin
            n.awv = 1'b1;
            n.awa = awaddr_i;
        end
        if (wvalid_i && wready_o) begin
            n.wv = 1'b1;
            n.wd = wdata_i;
            n.ws = wstrb_i;
        end
        if (wr_now) begin
            n.awv = 1'b0;
            n.wv  = 1'b0;
            n.bv  = 1'b1;
            n.br  = addr_ok(q.awa) ? gpios_pkg::RESP_OKAY : gpios_pkg::RESP_SLV;
            case (q.awa)
                gpios_pkg::OFS_DIR:     n.dir = (q.dir & ~m[NP-1:0]) | wn;
                gpios_pkg::OFS_DIRSET:  n.dir = q.dir | wn;
                gpios_pkg::OFS_DIRCLR:  n.dir = q.dir & ~wn;
                gpios_pkg::OFS_DIRTGL:  n.dir = q.dir ^ wn;
                gpios_pkg::OFS_OUT:     n.out = (q.out & ~m[NP-1:0]) | wn;
                gpios_pkg::OFS_OUTSET:  n.out = q.out | wn;
                gpios_pkg::OFS_OUTCLR:  n.out = q.out & ~wn;
                gpios_pkg::OFS_OUTTGL:  n.out = q.out ^ wn;
                gpios_pkg::OFS_MPCMASK: n.mpc = (q.mpc & ~m[NP-1:0]) | wn;
                gpios_pkg::OFS_CFGALL: begin
                    for (int i = 0; i < NP; i++) begin
                        if (q.mpc[i] && q.ws[0]) begin
                            n.cfg[i] = w[gpios_pkg::CFG_W-1:0];
                        end
                    end
                end
                gpios_pkg::OFS_INT0M:   n.m0 = (q.m0 & ~m[NP-1:0]) | wn;
                gpios_pkg::OFS_INT1M:   n.m1 = (q.m1 & ~m[NP-1:0]) | wn;
                gpios_pkg::OFS_BITOP: begin
                    if (q.ws[0] && int'(b) < NP) begin
                        if (w[gpios_pkg::BOP_TGT_BIT]) begin
                            n.out[b] = w[gpios_pkg::BOP_VAL_BIT];
                        end else begin
                            n.dir[b] = w[gpios_pkg::BOP_VAL_BIT];
                        end
                    end
                end
                gpios_pkg::OFS_OUTCTL:  n.octl = (q.octl & ~m[gpios_pkg::OCT_W-1:0]) | w[gpios_pkg::OCT_W-1:0];
                gpios_pkg::OFS_REMAP:   n.remap = (q.remap & ~m[3:0]) | w[3:0];
                default: begin
                    if (cfg_hit(q.awa) && q.ws[0]) begin
                        n.cfg[q.awa[4:2]] = w[gpios_pkg::CFG_W-1:0];
                    end
                end
            endcase
        end else if (q.bv && bready_i) begin
            n.bv = 1'b0;
        end
        // Pad drive, pull and overrides per pin
        for (int i = 0; i < NP; i++) begin
            opc = q.cfg[i][gpios_pkg::CFG_OPC_LSB +: 3];
            v   = q.out[i] ^ q.cfg[i][gpios_pkg::CFG_INV_BIT];
            if (q.octl[gpios_pkg::OCT_PCLK_EN] && q.octl[gpios_pkg::OCT_PCLK_LSB +: 3] == 3'(i)) begin
                v = q.pdiv;
            end
            if (q.octl[gpios_pkg::OCT_RTC_EN] && q.octl[gpios_pkg::OCT_RTC_LSB +: 3] == 3'(i)) begin
                v = q.rstab;
            end
            if (q.octl[gpios_pkg::OCT_EVO_EN] && q.octl[gpios_pkg::OCT_EVO_LSB +: 3] == 3'(i)) begin
                v = ev_chan_i[q.octl[gpios_pkg::OCT_EVCH_LSB +: 2]];
            end
            oe = q.dir[i];
            pe = 1'b0;
            pu = 1'b0;
            case (opc)
                gpios_pkg::OPC_KEEP: begin
                    pe = 1'b1;
                    pu = q.stab[i];
                end
                gpios_pkg::OPC_PD:     pe = ~q.dir[i];
                gpios_pkg::OPC_PU: begin
                    pe = ~q.dir[i];
                    pu = 1'b1;
                end
                gpios_pkg::OPC_WOR:    oe = q.dir[i] & v;
                gpios_pkg::OPC_WAND:   oe = q.dir[i] & ~v;
                gpios_pkg::OPC_WORPD: begin
                    oe = q.dir[i] & v;
                    pe = 1'b1;
                end
                gpios_pkg::OPC_WANDPU: begin
                    oe = q.dir[i] & ~v;
                    pe = 1'b1;
                    pu = 1'b1;
                end
                default: ;
            endcase
            if (alt_en_i[i]) begin
                v  = alt_out_i[i];
                oe = alt_oe_i[i];
            end
            n.pdo[i] = v;
            n.poe[i] = oe;
            n.pen[i] = pe;
            n.pup[i] = pu;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q       <= '0;
            q.dir   <= gpios_pkg::RST_PORT[NP-1:0];
            q.out   <= gpios_pkg::RST_PORT[NP-1:0];
            q.cfg   <= {NP{gpios_pkg::RST_CFG}};
            q.octl  <= gpios_pkg::RST_OUTCTL;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign bvalid_o  = q.bv;
    assign bresp_o   = q.br;
    assign rvalid_o  = q.rv;
    assign rdata_o   = q.rd;
    assign rresp_o   = q.rr;
    assign pad_out_o = q.pdo;
    assign pad_oe_o  = q.poe;
    assign pull_en_o = q.pen;
    assign pull_up_o = q.pup;
    assign remap_o   = q.remap;
    assign evt_o     = q.evt;
    assign int0_o    = |(q.flg & q.m0);
    assign int1_o    = |(q.flg & q.m1);

    // Asynchronous sensing: raw pin against last stable level, no clock needed
    always_comb begin
        logic inv;
        wake_o = 1'b0;
        inv    = 1'b0;
        if (!pclk_en_i) begin
            for (int i = 0; i < NP; i++) begin
                inv = q.cfg[i][gpios_pkg::CFG_INV_BIT];
                if ((q.m0[i] | q.m1[i]) && sense(q.cfg[i][gpios_pkg::CFG_ISC_LSB +: 2],
                                                 q.stab[i] ^ inv, pad_in_i[i] ^ inv)) begin
                    wake_o = 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    property p_sync;
        ((q.stab ^ $past(q.stab)) & ~$past(agree)) == '0;
    endproperty
    a_sync: assert property (p_sync) else $error("stable pin changed before stages agreed");
    property p_dirset;
        wr_now && q.awa == gpios_pkg::OFS_DIRSET && q.ws[0] |=> q.dir == ($past(q.dir) | $past(q.wd[NP-1:0]));
    endproperty
    a_dirset: assert property (p_dirset) else $error("direction set touched other pins");
    property p_outtgl;
        wr_now && q.awa == gpios_pkg::OFS_OUTTGL && q.ws[0] |=> q.out == ($past(q.out) ^ $past(q.wd[NP-1:0]));
    endproperty
    a_outtgl: assert property (p_outtgl) else $error("output toggle wrong");
    property p_multi;
        wr_now && q.awa == gpios_pkg::OFS_CFGALL && q.ws[0] && q.mpc[0]
            |=> q.cfg[0] == $past(q.wd[gpios_pkg::CFG_W-1:0]);
    endproperty
    a_multi: assert property (p_multi) else $error("multi-pin config missed pin 0");
    property p_rise;
        pclk_en_i && q.cfg[0] == 6'h01 && !q.stab[0] && agree[0] && q.s3[0] |=> evt_o[0] && q.flg[0] ##1 !evt_o[0];
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge not sensed");
    property p_inv;
        pclk_en_i && q.cfg[0] == 6'h23 && agree[0] && q.s3[0] |=> evt_o[0] && q.flg[0];
    endproperty
    a_inv: assert property (p_inv) else $error("inverted low level not sensed");
    property p_keep;
        q.cfg[0][4:2] == gpios_pkg::OPC_KEEP && !alt_en_i[0] |=> pull_en_o[0] && pull_up_o[0] == $past(q.stab[0]);
    endproperty
    a_keep: assert property (p_keep) else $error("keeper not holding last level");
    property p_alt;
        alt_en_i[0] |=> pad_oe_o[0] == $past(alt_oe_i[0]) && pad_out_o[0] == $past(alt_out_i[0]);
    endproperty
    a_alt: assert property (p_alt) else $error("alternate function ignored");
    property p_int;
        evt_o[0] && q.m1[0] |-> int1_o ##1 (int1_o || ($past(arvalid_i) && $past(araddr_i) == gpios_pkg::OFS_FLAGS));
    endproperty
    a_int: assert property (p_int) else $error("masked event missed interrupt");
    property p_wake;
        !pclk_en_i && q.m0[0] && q.cfg[0] == 6'h03 && !pad_in_i[0] |-> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on low level");
    property p_sleep;
        !pclk_en_i |=> q.evt == '0;
    endproperty
    a_sleep: assert property (p_sleep) else $error("synchronous event while clock off");
    c_write: cover property (wr_now ##1 bvalid_o && bready_i);
    c_irq:   cover property (evt_o[0] && q.m0[0] ##1 int0_o);
    c_wake:  cover property (!pclk_en_i && wake_o);
endmodule // gpios_port

/* File: testbench/gpios_pads.sv */
// Board-side pad model for the sensing GPIO port.
// Assumes the bench supplies a per-pin board drive level and enable.
`timescale 1ns/1ps
module gpios_pads #(
    parameter int NP = 8
) (
    input  wire logic          clk_i,
    input  wire logic [NP-1:0] pad_out_i,
    input  wire logic [NP-1:0] pad_oe_i,
    input  wire logic [NP-1:0] pull_en_i,
    input  wire logic [NP-1:0] pull_up_i,
    input  wire logic [NP-1:0] ext_en_i,
    input  wire logic [NP-1:0] ext_val_i,
    output logic      [NP-1:0] pad_lvl_o
);
    logic [NP-1:0] last_q;
    // Port drive wins, then board drive, then a weak pull; a floating pin flips
    assign pad_lvl_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i)
                     | (~pad_oe_i & ~ext_en_i & pull_en_i & pull_up_i)
                     | (~pad_oe_i & ~ext_en_i & ~pull_en_i & ~last_q);
    always_ff @(posedge clk_i) last_q <= pad_lvl_o;
endmodule // gpios_pads

/* File: testbench/test_gpios_port.sv */
// Self-checking bench: register access, pin sensing, interrupts and overrides.
// Assumes gpios_pkg, gpios_port and gpios_pads are compiled first.
`timescale 1ns/1ps
module test_gpios_port;
    logic        clk_i = 0, srst_i = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, int0, int1, ta, tw, tb, wake;
    logic        pclk_en = 1, rtc = 0;
    logic [7:0]  awaddr = 0, araddr = 0, ext_val = 8'h02, alt_en = 0, alt_out = 0, alt_oe = 0;
    logic [7:0]  pad_lvl, pad_out, pad_oe, pull_en, pull_up;
    logic [31:0] wdata = 0, rdata, rv;
    logic [1:0]  bresp, rresp, resp;
    logic [3:0]  remap, evch = 0;
    int          fails = 0, comparisons = 0, cyc = 0;
    always #12.5 clk_i = ~clk_i;
    gpios_port gpios_port_i (
        .clk_i(clk_i), .srst_i(srst_i), .pclk_en_i(pclk_en), .awaddr_i(awaddr), .awvalid_i(awvalid),
        .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'hf), .wvalid_i(wvalid), .wready_o(wready),
        .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
        .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
        .pad_in_i(pad_lvl), .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pull_en_o(pull_en), .pull_up_o(pull_up),
        .rtc_clk_i(rtc), .ev_chan_i(evch), .alt_en_i(alt_en), .alt_out_i(alt_out), .alt_oe_i(alt_oe),
        .remap_o(remap), .evt_o(), .int0_o(int0), .int1_o(int1), .wake_o(wake));
    gpios_pads gpios_pads_i (
        .clk_i(clk_i), .pad_out_i(pad_out), .pad_oe_i(pad_oe), .pull_en_i(pull_en), .pull_up_i(pull_up),
        .ext_en_i(8'hff), .ext_val_i(ext_val), .pad_lvl_o(pad_lvl));
    // ------------------------------------------------------------------
    // Bus tasks and checking
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Handshakes are sampled mid-cycle, where they equal the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge clk_i);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            resp = bresp;
            @(posedge clk_i);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
        @(posedge clk_i);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge clk_i);
            ta = arvalid & arready;
            tb = rvalid;
            rv = rdata;
            resp = rresp;
            @(posedge clk_i);
            if (ta) arvalid <= 1'b0;
        end while (!tb);
        rready <= 1'b0;
        chk(rv & m, e);
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        rd(gpios_pkg::OFS_DIR, 32'h0);
        wr(gpios_pkg::OFS_DIRSET, 32'h05);
        wr(gpios_pkg::OFS_DIRCLR, 32'h01);
        rd(gpios_pkg::OFS_DIR, 32'h04);
        wr(gpios_pkg::OFS_DIRTGL, 32'h03);
        rd(gpios_pkg::OFS_DIR, 32'h07);
        chk(pad_oe, 8'h07);
        wr(gpios_pkg::OFS_OUTSET, 32'hf0);
        wr(gpios_pkg::OFS_OUTCLR, 32'h30);
        wr(gpios_pkg::OFS_OUTTGL, 32'h81);
        wr(gpios_pkg::OFS_BITOP, 32'h1b);
        rd(gpios_pkg::OFS_OUT, 32'h49);
        rd(8'h7c, 32'h0);
        chk(resp, gpios_pkg::RESP_OKAY);
        rd(8'h44, 32'h0);
        chk(resp, gpios_pkg::RESP_SLV);
        wr(8'h44, 32'hff);
        chk(resp, gpios_pkg::RESP_SLV);
        wr(gpios_pkg::OFS_REMAP, 32'h5);
        chk(resp, gpios_pkg::RESP_OKAY);
        chk(remap, 4'h5);
        wr(gpios_pkg::OFS_DIR, 32'h0);
        wr(gpios_pkg::OFS_MPCMASK, 32'h0d);
        wr(gpios_pkg::OFS_CFGALL, {27'h0, gpios_pkg::OPC_PU, 2'h0});
        @(negedge clk_i);
        chk({pull_en, pull_up}, 16'h0d0d);
        wr(8'h70, {27'h0, gpios_pkg::OPC_KEEP, 2'h0});
        wr(8'h60, {27'h0, gpios_pkg::OPC_KEEP, 2'h0});
        repeat (8) @(posedge clk_i);
        chk({pull_en[4], pull_up[4], pull_en[0], pull_up[0]}, 4'b1010);
        ext_val <= 8'h12;
        repeat (8) @(posedge clk_i);
        chk({pull_en[4], pull_up[4]}, 2'b11);
        wr(8'h60, {30'h0, gpios_pkg::ISC_RISE});
        wr(8'h64, 32'h21);
        wr(gpios_pkg::OFS_INT0M, 32'h01);
        wr(gpios_pkg::OFS_INT1M, 32'h03);
        rd(gpios_pkg::OFS_FLAGS, 32'h0, 32'h0);
        ext_val <= 8'h13;
        for (int i = 0; i < 12 && int0 !== 1'b1; i++) @(negedge clk_i);
        chk(int0, 1'b1);
        rd(gpios_pkg::OFS_FLAGS, 32'h01);
        rd(gpios_pkg::OFS_FLAGS, 32'h00);
        ext_val <= 8'h10;
        for (int i = 0; i < 12 && int1 !== 1'b1; i++) @(negedge clk_i);
        chk(int1, 1'b1);
        rd(gpios_pkg::OFS_FLAGS, 32'h02);
        // Inverted low-level sense: a high pin reads as a low level
        wr(8'h60, 32'h23);
        ext_val <= 8'h11;
        repeat (6) @(posedge clk_i);
        rd(gpios_pkg::OFS_FLAGS, 32'h01);
        // Sleep: only the asynchronous wake path reacts
        wr(8'h60, 32'h03);
        pclk_en <= 1'b0;
        rd(gpios_pkg::OFS_FLAGS, 32'h0, 32'h0);
        chk(wake, 1'b0);
        ext_val <= 8'h10;
        @(negedge clk_i);
        chk(wake, 1'b1);
        repeat (6) @(posedge clk_i);
        rd(gpios_pkg::OFS_FLAGS, 32'h0);
        pclk_en <= 1'b1;
        // RTC clock on pin 4, event channel 2 on pin 5
        wr(gpios_pkg::OFS_DIRSET, 32'h30);
        wr(gpios_pkg::OFS_OUTCTL, 32'h2dc0);
        rtc  <= 1'b1;
        evch <= 4'h4;
        repeat (6) @(posedge clk_i);
        chk(pad_out[4], 1'b1);
        chk(pad_out[5], 1'b1);
        alt_en  <= 8'h81;
        alt_oe  <= 8'h81;
        alt_out <= 8'h80;
        repeat (3) @(posedge clk_i);
        chk({pad_oe[7], pad_out[7], pad_oe[0], pad_out[0]}, 4'b1110);
        report_and_stop();
    end
endmodule // test_gpios_port
